// *** rtl/mah_csr.sv ***
// station address, multicast hash table and phy management registers
//
// Notes on behaviour
// (R1) address-low register holds station address bits 31:0, host read/write
// (R2) at power-on a programmed eeprom loads the address, else load skipped
// (R3) eeprom bytes 1..4 fill address-low bytes, bytes 5..6 address-high
// (R4) address-low bits 7:0 are the first byte on the wire
// (R5) host writes overwrite the address once loading is over
// (R6) 6-bit hash index: top bit picks table word, five bits pick bit
// (R7) in-word index is linear, zeros bit 0 low, ones bit 31 high
// (R8) group frame accepted when selected table bit is one, else rejected
// (R9) accept-all-group bit accepts every group frame
// (R10) table bits 63:32 high register, 31:0 low, read/write, reset zero
// (R11) control bits 15:11 give phy address; internal phy is address 1
// (R12) control bits 10:6 give the phy register index
// (R13) bit 1 set writes data register to phy, clear reads into it
// (R14) writing busy bit starts a cycle; stays set until completion
// (R15) host waits for busy clear before writing control or data
// (R16) host keeps data register unchanged during a write cycle
// (R17) read data valid in data register no later than busy clears
// (R18) data register low 16 bits carry phy data, upper bits reserved
// (R19) each cycle is a clause 22 frame on the mdc/mdio pair
`timescale 1ns/10ps
`include "mah_regs.svh"
module mah_csr
	import mah_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic eeprom_load_valid,
	input wire logic [2:0] eeprom_load_index,
	input wire logic [7:0] eeprom_load_byte,
	input wire logic eeprom_load_done,
	input wire logic [5:0] hash_index,
	output logic group_accept,
	output logic [47:0] station_address,
	output logic init_done,
	output logic internal_phy_select,
	output logic mdc,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic mdio_in
);
	mah_bus_t bus;
	logic [31:0] station_address_low_reg;
	logic [15:0] station_address_high_reg;
	logic [31:0] multicast_table_upper_reg;
	logic [31:0] multicast_table_lower_reg;
	logic [4:0] phy_addr_reg;
	logic [4:0] phy_register_index_reg;
	logic phy_write_not_read_reg;
	logic phy_access_busy_reg;
	logic [15:0] mgmt_data_reg;
	logic accept_all_group_frames_reg;
	logic init_done_reg;
	logic [31:0] reg_rdata_reg;
	logic start_pulse_reg;
	logic eng_busy;
	logic eng_done;
	logic [15:0] eng_rdata;
	mah_mgmt_req_t mreq;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
		hit = (a == idx);
	endfunction : hit

	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// address registers: eeprom load first, host writes only after init
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			station_address_low_reg <= `MAH_RST_ADDR_LOW;
			station_address_high_reg <= `MAH_RST_ADDR_HIGH;
			init_done_reg <= 1'b0;
		end else if (!init_done_reg) begin
			if (eeprom_load_valid) begin // R2
				unique case (eeprom_load_index)
					3'h1: station_address_low_reg[7:0] <= eeprom_load_byte; // R3
					3'h2: station_address_low_reg[15:8] <= eeprom_load_byte; // R3
					3'h3: station_address_low_reg[23:16] <= eeprom_load_byte; // R3
					3'h4: station_address_low_reg[31:24] <= eeprom_load_byte; // R3
					3'h5: station_address_high_reg[7:0] <= eeprom_load_byte; // R3
					3'h6: station_address_high_reg[15:8] <= eeprom_load_byte; // R3
					default: ;
				endcase
			end
			// no programmed eeprom: controller signals done with no bytes
			if (eeprom_load_done)
				init_done_reg <= 1'b1;
		end else if (bus.wr) begin
			if (hit(bus.addr, `MAH_IDX_ADDR_LOW))
				station_address_low_reg <= bus.wdata; // R1 R5
			if (hit(bus.addr, `MAH_IDX_ADDR_HIGH))
				station_address_high_reg <= bus.wdata[15:0]; // R5
		end
	end

	// wire order: low byte 0 first, high byte 1 last
	assign station_address = {station_address_high_reg, station_address_low_reg}; // R4
	assign init_done = init_done_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			multicast_table_upper_reg <= `MAH_RST_ZERO; // R10
			multicast_table_lower_reg <= `MAH_RST_ZERO; // R10
			accept_all_group_frames_reg <= 1'b0;
		end else if (bus.wr) begin
			if (hit(bus.addr, `MAH_IDX_TABLE_HI))
				multicast_table_upper_reg <= bus.wdata; // R10
			if (hit(bus.addr, `MAH_IDX_TABLE_LO))
				multicast_table_lower_reg <= bus.wdata; // R10
			if (hit(bus.addr, `MAH_IDX_FILT_CTL))
				accept_all_group_frames_reg <= bus.wdata[0]; // R9
		end
	end

	mah_hash_filter u_hash (
		.table_bits({multicast_table_upper_reg, multicast_table_lower_reg}),
		.hash_index(hash_index),
		.accept_all_group_frames(accept_all_group_frames_reg),
		.group_accept(group_accept)
	);

	// control register; writes while busy are ignored to protect the frame
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phy_addr_reg <= 5'h00;
			phy_register_index_reg <= 5'h00;
			phy_write_not_read_reg <= 1'b0;
			phy_access_busy_reg <= 1'b0;
			start_pulse_reg <= 1'b0;
		end else begin
			start_pulse_reg <= 1'b0;
			if (bus.wr && hit(bus.addr, `MAH_IDX_MGMT_CTL) && !phy_access_busy_reg) begin // R15
				phy_addr_reg <= bus.wdata[15:11]; // R11
				phy_register_index_reg <= bus.wdata[10:6]; // R12
				phy_write_not_read_reg <= bus.wdata[`MAH_BIT_WNR]; // R13
				if (bus.wdata[`MAH_BIT_BUSY]) begin
					phy_access_busy_reg <= 1'b1; // R14
					start_pulse_reg <= 1'b1;
				end
			end else if (eng_done) begin
				phy_access_busy_reg <= 1'b0; // R14
			end
		end
	end

	assign internal_phy_select = (phy_addr_reg == `MAH_INT_PHY); // R11

	// data register: host writes when idle, engine result lands on the same edge that clears busy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mgmt_data_reg <= 16'h0000;
		end else if (eng_done && !phy_write_not_read_reg) begin
			mgmt_data_reg <= eng_rdata; // R17 R18
		end else if (bus.wr && hit(bus.addr, `MAH_IDX_MGMT_DATA) && !phy_access_busy_reg) begin
			mgmt_data_reg <= bus.wdata[15:0]; // R16 R18
		end
	end

	assign mreq = '{start: start_pulse_reg, write_not_read: phy_write_not_read_reg,
		phy_addr: phy_addr_reg, reg_index: phy_register_index_reg,
		wdata: mgmt_data_reg};

	mah_mdio u_mdio (
		.clk(clk),
		.nrst(nrst),
		.req(mreq),
		.busy(eng_busy),
		.done(eng_done),
		.rdata(eng_rdata),
		.mdc(mdc),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.mdio_in(mdio_in)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata_reg <= `MAH_RST_ZERO;
		end else if (bus.rd) begin
			unique case (bus.addr)
				`MAH_IDX_ADDR_HIGH: reg_rdata_reg <= {16'h0000, station_address_high_reg};
				`MAH_IDX_ADDR_LOW: reg_rdata_reg <= station_address_low_reg; // R1
				`MAH_IDX_TABLE_HI: reg_rdata_reg <= multicast_table_upper_reg;
				`MAH_IDX_TABLE_LO: reg_rdata_reg <= multicast_table_lower_reg;
				`MAH_IDX_MGMT_CTL: reg_rdata_reg <= {16'h0000, phy_addr_reg,
					phy_register_index_reg, 4'h0, phy_write_not_read_reg,
					phy_access_busy_reg};
				`MAH_IDX_MGMT_DATA: reg_rdata_reg <= {16'h0000, mgmt_data_reg};
				`MAH_IDX_FILT_CTL: reg_rdata_reg <= {31'h0, accept_all_group_frames_reg};
				default: reg_rdata_reg <= `MAH_RST_ZERO;
			endcase
		end else begin
			reg_rdata_reg <= `MAH_RST_ZERO;
		end
	end
	assign reg_rdata = reg_rdata_reg;

	a_busy_start: assert property (@(posedge clk) disable iff (!nrst)
		start_pulse_reg |-> phy_access_busy_reg) else $error("busy not set at start"); // R14
	a_busy_engine: assert property (@(posedge clk) disable iff (!nrst)
		eng_busy |-> phy_access_busy_reg) else $error("busy low during cycle"); // R14
	a_busy_clear: assert property (@(posedge clk) disable iff (!nrst)
		eng_done |=> !phy_access_busy_reg) else $error("busy not cleared"); // R14
	a_read_data: assert property (@(posedge clk) disable iff (!nrst)
		(eng_done && !phy_write_not_read_reg) |=> mgmt_data_reg == $past(eng_rdata))
		else $error("read data not stored"); // R17
	a_hash_pick: assert property (@(posedge clk) disable iff (!nrst)
		!accept_all_group_frames_reg |-> group_accept ==
		({multicast_table_upper_reg, multicast_table_lower_reg} >> hash_index) % 2)
		else $error("hash lookup wrong"); // R8
	a_pass_all: assert property (@(posedge clk) disable iff (!nrst)
		accept_all_group_frames_reg |-> group_accept) else $error("pass all broken"); // R9
	a_table_write: assert property (@(posedge clk) disable iff (!nrst)
		bus.wr && bus.addr == `MAH_IDX_TABLE_HI |=> multicast_table_upper_reg == $past(bus.wdata))
		else $error("table write lost"); // R10
	a_addr_write: assert property (@(posedge clk) disable iff (!nrst)
		init_done_reg && bus.wr && bus.addr == `MAH_IDX_ADDR_LOW
		|=> station_address_low_reg == $past(bus.wdata)) else $error("address write lost"); // R1 R5
	a_ctl_fields: assert property (@(posedge clk) disable iff (!nrst)
		start_pulse_reg |-> phy_addr_reg == $past(bus.wdata[15:11]) &&
		phy_register_index_reg == $past(bus.wdata[10:6])) else $error("fields wrong"); // R11 R12
	// read data only stands in the cycle after a read strobe
	a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
		!bus.rd |=> reg_rdata_reg == `MAH_RST_ZERO) else $error("read data not idle");
	a_addr_locked: assert property (@(posedge clk) disable iff (!nrst) // R5
		!init_done_reg && !eeprom_load_valid && bus.wr && bus.addr == `MAH_IDX_ADDR_LOW
		|=> $stable(station_address_low_reg)) else $error("early address write taken");
	a_ctl_guard: assert property (@(posedge clk) disable iff (!nrst) // R15
		phy_access_busy_reg && bus.wr && bus.addr == `MAH_IDX_MGMT_CTL
		|=> $stable(phy_addr_reg) && $stable(phy_register_index_reg))
		else $error("control changed while busy");
	a_data_guard: assert property (@(posedge clk) disable iff (!nrst) // R16
		phy_access_busy_reg && phy_write_not_read_reg |=> $stable(mgmt_data_reg))
		else $error("data changed during phy write");
	c_pass_all: cover property (@(posedge clk) accept_all_group_frames_reg && group_accept);
	c_phy_read: cover property (@(posedge clk) eng_done && !phy_write_not_read_reg);
	c_phy_write: cover property (@(posedge clk) eng_done && phy_write_not_read_reg);
	c_eeprom: cover property (@(posedge clk) eeprom_load_valid && eeprom_load_index == 3'h6);
	c_reject: cover property (@(posedge clk) !group_accept);
endmodule : mah_csr

// *** rtl/mah_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef MAH_REGS_SVH
`define MAH_REGS_SVH
`define MAH_IDX_ADDR_LOW 4'h3
`define MAH_IDX_TABLE_HI 4'h4
`define MAH_IDX_TABLE_LO 4'h5
`define MAH_IDX_MGMT_CTL 4'h6
`define MAH_IDX_MGMT_DATA 4'h7
`define MAH_IDX_ADDR_HIGH 4'h2
`define MAH_IDX_FILT_CTL 4'h8
`define MAH_RST_ADDR_LOW 32'h0FFFFFFF
`define MAH_RST_ADDR_HIGH 16'hFFFF
`define MAH_RST_ZERO 32'h00000000
`define MAH_BIT_BUSY 0
`define MAH_BIT_WNR 1
`define MAH_INT_PHY 5'h01
`define MAH_MDC_HALF_NS 200
`define MAH_CLK_NS 10
`define MAH_MDC_HALF_CYC ((`MAH_MDC_HALF_NS + `MAH_CLK_NS - 1) / `MAH_CLK_NS)
`define MAH_FRAME_BITS 7'd64
`endif

// *** rtl/mah_pkg.sv ***
// types shared by the address, hash and management files
package mah_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} mah_bus_t;
	typedef struct packed {
		logic start;
		logic write_not_read;
		logic [4:0] phy_addr;
		logic [4:0] reg_index;
		logic [15:0] wdata;
	} mah_mgmt_req_t;
	typedef enum logic [1:0] {
		MAH_IDLE = 2'b00,
		MAH_SHIFT = 2'b01,
		MAH_DONE = 2'b10
	} mah_mgmt_state_t;
endpackage : mah_pkg

// *** rtl/mah_hash_filter.sv ***
// multicast hash table lookup
`timescale 1ns/10ps
module mah_hash_filter
	import mah_pkg::*;
(
	input wire logic [63:0] table_bits,
	input wire logic [5:0] hash_index,
	input wire logic accept_all_group_frames,
	output logic group_accept
);
	logic [31:0] word_sel;
	assign word_sel = hash_index[5] ? table_bits[63:32] : table_bits[31:0]; // R6
	// in-word index linear, 0 is bit 0, 31 is bit 31
	assign group_accept = accept_all_group_frames | word_sel[hash_index[4:0]]; // R7 R8 R9
endmodule : mah_hash_filter

// *** rtl/mah_mdio.sv ***
// clause 22 management frame engine on mdc/mdio
`timescale 1ns/10ps
`include "mah_regs.svh"
module mah_mdio
	import mah_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire mah_mgmt_req_t req,
	output logic busy,
	output logic done,
	output logic [15:0] rdata,
	output logic mdc,
	output logic mdio_out,
	output logic mdio_oe_n,
	input wire logic mdio_in
);
	localparam int HALF = `MAH_MDC_HALF_CYC;
	mah_mgmt_state_t state_reg;
	logic [7:0] div_reg;
	logic [6:0] bit_reg;
	logic [63:0] shift_reg;
	logic [15:0] rdata_reg;
	logic done_reg;
	logic mdc_reg;
	logic oe_n_reg;
	logic [2:0] in_sync_reg;
	logic in_stable_reg;
	logic rise;
	assign rise = (state_reg == MAH_SHIFT) && (div_reg == 8'(HALF - 1)) && !mdc_reg;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			in_sync_reg <= 3'h0;
			in_stable_reg <= 1'b0;
		end else begin
			in_sync_reg <= {in_sync_reg[1:0], mdio_in};
			if (in_sync_reg[1] == in_sync_reg[2])
				in_stable_reg <= in_sync_reg[2];
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= MAH_IDLE;
			div_reg <= 8'h00;
			bit_reg <= 7'h00;
			shift_reg <= 64'h0;
			mdc_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			rdata_reg <= 16'h0000;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			unique case (state_reg)
				MAH_IDLE: begin
					if (req.start) begin
						// preamble 32 ones, start, opcode, phy, reg, turnaround, data
						shift_reg <= {32'hFFFFFFFF, 2'b01,
							req.write_not_read ? 2'b01 : 2'b10,
							req.phy_addr, req.reg_index, 2'b10, req.wdata}; // R19
						bit_reg <= 7'h00;
						div_reg <= 8'h00;
						mdc_reg <= 1'b0;
						oe_n_reg <= 1'b0;
						state_reg <= MAH_SHIFT;
					end
				end
				MAH_SHIFT: begin
					if (div_reg == 8'(HALF - 1)) begin
						div_reg <= 8'h00;
						mdc_reg <= !mdc_reg;
						if (mdc_reg) begin
							// falling edge: present next bit
							shift_reg <= {shift_reg[62:0], 1'b0};
							bit_reg <= bit_reg + 7'd1;
							if (!req.write_not_read && bit_reg == 7'd45)
								oe_n_reg <= 1'b1; // release for turnaround on reads
							if (bit_reg == `MAH_FRAME_BITS - 7'd1)
								state_reg <= MAH_DONE;
						end
					end else begin
						div_reg <= div_reg + 8'd1;
					end
					if (rise && !req.write_not_read && bit_reg >= 7'd48)
						rdata_reg <= {rdata_reg[14:0], in_stable_reg}; // R13
				end
				MAH_DONE: begin
					oe_n_reg <= 1'b1;
					done_reg <= 1'b1;
					state_reg <= MAH_IDLE;
				end
				default: state_reg <= MAH_IDLE;
			endcase
		end
	end
	assign busy = (state_reg != MAH_IDLE);
	assign done = done_reg;
	assign rdata = rdata_reg;
	assign mdc = mdc_reg;
	assign mdio_out = shift_reg[63];
	assign mdio_oe_n = oe_n_reg;
endmodule : mah_mdio

// *** tb/mah_phy_model.sv ***
// management side of a phy: decodes frames, answers reads, records writes
`timescale 1ns/10ps
module mah_phy_model (
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	output logic mdio_in,
	output logic [15:0] wr_value,
	output logic [9:0] target
);
	logic [15:0] sr = 16'hFFFF;
	logic [16:0] rsh = 17'h1FFFF;
	logic rd_op = 1'b0;
	logic drive = 1'b0;
	int cnt = -1;

	// pull-up holds the line high whenever nobody drives it
	assign mdio_in = !mdio_oe_n ? mdio_out : (drive ? rsh[16] : 1'b1);

	always @(posedge mdc) begin
		sr <= {sr[14:0], mdio_in};
		if (cnt < 0) begin
			if (sr[1:0] == 2'b10 && mdio_in) cnt <= 0;
		end else if (cnt == 29) begin
			if (!rd_op) wr_value <= {sr[14:0], mdio_in};
			cnt <= -1;
		end else begin
			cnt <= cnt + 1;
		end
		if (cnt == 1) rd_op <= ({sr[0], mdio_in} == 2'b10);
		if (cnt == 11) target <= {sr[8:0], mdio_in};
	end

	// read answer: second turnaround bit low, then data msb first
	always @(negedge mdc) begin
		if (rd_op && cnt == 13) begin
			drive <= 1'b1;
			rsh <= {1'b0, 6'h2D, target};
		end else if (cnt >= 14) begin
			rsh <= {rsh[15:0], 1'b1};
		end else if (cnt < 0) begin
			drive <= 1'b0;
		end
	end
endmodule : mah_phy_model

// *** tb/mac_addr_hash_mii_access_test.sv ***
// self-checking bench for address, hash table and phy management registers
`timescale 1ns/10ps
`include "mah_regs.svh"
`define TB_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module mac_addr_hash_mii_access_test;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic ee_valid = 1'b0;
	logic [2:0] ee_index = 3'h0;
	logic [7:0] ee_byte = 8'h0;
	logic ee_done = 1'b0;
	logic [5:0] hash_index = 6'h0;
	logic group_accept, init_done, internal_phy_select, mdc, mdio_out, mdio_oe_n, mdio_in;
	logic [47:0] station_address;
	logic [15:0] phy_wr_value;
	logic [9:0] phy_target;
	logic [31:0] v;
	logic [63:0] tbl;
	int error_cnt = 0;
	int cmp_count = 0;

	always #5 clk = ~clk;

	mah_csr mah_csr_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eeprom_load_valid(ee_valid),
		.eeprom_load_index(ee_index), .eeprom_load_byte(ee_byte), .eeprom_load_done(ee_done),
		.hash_index(hash_index), .group_accept(group_accept), .station_address(station_address),
		.init_done(init_done), .internal_phy_select(internal_phy_select), .mdc(mdc),
		.mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdio_in(mdio_in));
	mah_phy_model mah_phy_model_i (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
		.mdio_in(mdio_in), .wr_value(phy_wr_value), .target(phy_target));

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// host may touch control or data only after busy reads back clear
	task automatic wait_idle();
		int n;
		n = 0;
		rd(`MAH_IDX_MGMT_CTL, v);
		while (v[0] !== 1'b0 && n < 5000) begin
			rd(`MAH_IDX_MGMT_CTL, v);
			n++;
		end
		`TB_CHK(v[0], 1'b0)
	endtask : wait_idle

	task automatic finish_test();
		if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	initial begin
		repeat (6) @(posedge clk);
		`TB_CHK(station_address, {`MAH_RST_ADDR_HIGH, `MAH_RST_ADDR_LOW})
		nrst <= 1'b1;
		rd(`MAH_IDX_ADDR_LOW, v);
		`TB_CHK(v, `MAH_RST_ADDR_LOW)
		foreach (tbl[i]) if (i >= 4 && i <= 8 || i == 15) begin
			rd(i[3:0], v);
			`TB_CHK(v, 32'h0)
		end
		// address writes before the load finishes must be dropped
		wr(`MAH_IDX_ADDR_LOW, 32'h11111111);
		rd(`MAH_IDX_ADDR_LOW, v);
		`TB_CHK(v, `MAH_RST_ADDR_LOW)
		for (int i = 1; i <= 6; i++) begin
			@(posedge clk);
			ee_valid <= 1'b1;
			ee_index <= i[2:0];
			ee_byte <= 8'h12 + 8'(i - 1) * 8'h22;
		end
		@(posedge clk);
		ee_valid <= 1'b0;
		ee_done <= 1'b1;
		@(posedge clk);
		ee_done <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		`TB_CHK(init_done, 1'b1)
		`TB_CHK(station_address, 48'hBC9A_7856_3412)
		`TB_CHK(station_address[7:0], 8'h12)
		rd(`MAH_IDX_ADDR_LOW, v);
		`TB_CHK(v, 32'h7856_3412)
		wr(`MAH_IDX_ADDR_LOW, 32'hA5C3_0F96);
		rd(`MAH_IDX_ADDR_LOW, v);
		`TB_CHK(v, 32'hA5C3_0F96)
		tbl = {32'h8000_0001, 32'h0000_0002};
		wr(`MAH_IDX_TABLE_HI, tbl[63:32]);
		wr(`MAH_IDX_TABLE_LO, tbl[31:0]);
		rd(`MAH_IDX_TABLE_HI, v);
		`TB_CHK(v, tbl[63:32])
		rd(`MAH_IDX_TABLE_LO, v);
		`TB_CHK(v, tbl[31:0])
		for (int i = 0; i < 64; i++) begin
			@(posedge clk);
			hash_index <= i[5:0];
			#1;
			`TB_CHK(group_accept, tbl[i])
		end
		wr(`MAH_IDX_FILT_CTL, 32'h1);
		@(posedge clk);
		hash_index <= 6'h00;
		#1;
		`TB_CHK(group_accept, 1'b1)
		wr(`MAH_IDX_FILT_CTL, 32'h0);
		`TB_CHK(group_accept, 1'b0)
		// phy write to the internal phy
		wr(`MAH_IDX_MGMT_DATA, 32'h0000_1234);
		wr(`MAH_IDX_MGMT_CTL, {16'h0, 5'h01, 5'h04, 4'h0, 2'b11});
		`TB_CHK(internal_phy_select, 1'b1)
		rd(`MAH_IDX_MGMT_CTL, v);
		`TB_CHK(v[0], 1'b1)
		wait_idle();
		`TB_CHK(phy_wr_value, 16'h1234)
		`TB_CHK(phy_target, {5'h01, 5'h04})
		// phy read from an external phy, data read right after busy clears
		wr(`MAH_IDX_MGMT_CTL, {16'h0, 5'h0A, 5'h1F, 4'h0, 2'b01});
		`TB_CHK(internal_phy_select, 1'b0)
		wait_idle();
		rd(`MAH_IDX_MGMT_DATA, v);
		`TB_CHK(v, {16'h0, 6'h2D, 5'h0A, 5'h1F})
		`TB_CHK(phy_target, {5'h0A, 5'h1F})
		finish_test();
	end
endmodule : mac_addr_hash_mii_access_test
